// ==== core/twbs_pkg.sv ====
package twbs_pkg;
  localparam int CLK_NS = 25;
  localparam int WD_TICK_NS = 30500;
  localparam int WD_TICK_CYC = (WD_TICK_NS / CLK_NS < 1) ? 1 : WD_TICK_NS / CLK_NS;
  localparam longint SUP_TIMEOUT_NS = 64'd1600000000;
  localparam int SUP_TIMEOUT_CYC = int'(SUP_TIMEOUT_NS / CLK_NS);
  localparam logic [7:0] ADDR_IDX = 8'h22;
  localparam logic [7:0] ADDR_DATA = 8'h23;
  localparam logic [7:0] ADDR_FST_RESTART = 8'h65;
  localparam logic [7:0] ADDR_SEC_RESTART = 8'h67;
  localparam logic [7:0] ADDR_SEC_CTRL = 8'h68;
  localparam logic [7:0] ADDR_SEC_EVT = 8'h69;
  localparam logic [7:0] ADDR_SEC_INT_LO = 8'h6A;
  localparam logic [7:0] ADDR_SEC_INT_MID = 8'h6B;
  localparam logic [7:0] ADDR_SEC_INT_HI = 8'h6C;
  localparam logic [7:0] ADDR_SEC_STATE = 8'h6D;
  localparam logic [7:0] IDX_FST_CTRL = 8'h37;
  localparam logic [7:0] IDX_FST_EVT = 8'h38;
  localparam logic [7:0] IDX_FST_INT_LO = 8'h39;
  localparam logic [7:0] IDX_FST_INT_MID = 8'h3A;
  localparam logic [7:0] IDX_FST_INT_HI = 8'h3B;
  localparam logic [7:0] IDX_FST_STATE = 8'h3C;
  localparam int EN_BIT = 6;
  localparam int RESTART_BIT = 6;
  localparam int FLAG_BIT = 7;
  localparam int EVT_LSB = 4;
  localparam logic [7:0] SEC_CTRL_RST = 8'h00;
  localparam logic [7:0] SEC_EVT_RST = 8'h00;
  localparam logic [23:0] SEC_INT_RST = 24'h000000;
  localparam logic [7:0] FST_CTRL_RST = 8'h40;
  localparam logic [7:0] FST_EVT_RST = 8'hD0;
  localparam logic [23:0] FST_INT_RST = 24'h200000;
  localparam logic [3:0] EVT_NMI = 4'hC;
  localparam logic [3:0] EVT_SYSRST = 4'hD;
  typedef struct packed {
    logic [7:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } twbs_io_req_t;
  typedef struct packed {
    logic en;
    logic [23:0] interval;
  } twbs_wd_cfg_t;
  typedef struct packed {
    logic [15:0] irq;
    logic nmi;
    logic sysrst;
  } twbs_evt_t;
endpackage

// ==== core/twbs_timer.sv ====
`timescale 1ns/1ps
module twbs_timer import twbs_pkg::*; #(
  parameter int TICK_CYC = WD_TICK_CYC
) (
  input wire logic clk,
  input wire logic rstn,
  input wire twbs_wd_cfg_t cfg,
  input wire logic restart,
  output logic expire
);
  localparam int PW = (TICK_CYC > 1) ? $clog2(TICK_CYC) : 1;
  logic [PW-1:0] pre_r;
  logic [23:0] cnt_r;
  logic fired_r;
  logic expire_r;
  wire tick = cfg.en && (pre_r == PW'(TICK_CYC - 1));
  wire [23:0] cnt_inc = cnt_r + 24'h000001;
  // holds after firing so the event goes out only once per restart or re-enable
  wire hit = tick && !fired_r && !restart && (cnt_inc >= cfg.interval);
  assign expire = expire_r;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pre_r <= '0;
      cnt_r <= 24'h000000;
      fired_r <= 1'b0;
      expire_r <= 1'b0;
    end else begin
      expire_r <= hit;
      if (restart || !cfg.en) begin
        pre_r <= '0;
        cnt_r <= 24'h000000;
        fired_r <= 1'b0;
      end else begin
        pre_r <= tick ? '0 : pre_r + PW'(1);
        if (tick && !fired_r) begin
          cnt_r <= cnt_inc;
        end
        if (hit) begin
          fired_r <= 1'b1;
        end
      end
    end
  end
  // prescales under 4 cycles are too close for this window
  tick_gap_a: assert property (@(posedge clk) disable iff (!rstn) (TICK_CYC >= 4) && tick |=> !tick [*3])
    else $error("count ticks too close");
  fire_once_a: assert property (@(posedge clk) disable iff (!rstn) expire |-> !hit)
    else $error("expiry fired twice");
endmodule

// ==== core/twbs_supervisor.sv ====
`timescale 1ns/1ps
module twbs_supervisor import twbs_pkg::*; #(
  parameter int TIMEOUT_CYC = SUP_TIMEOUT_CYC,
  parameter logic STRAP_DIS_LEVEL = 1'b1
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic svc_line,
  input wire logic en_line,
  input wire logic clr_line,
  input wire logic supervisor_wd_strap,
  input wire logic backup_enable_strap,
  input wire logic main_boot_return_strap,
  input wire logic isolated_reset_strap,
  input wire logic isolated_reset,
  input wire logic reset_pushbutton,
  input wire logic ext_restart,
  output logic state,
  output logic boot_backup,
  output logic module_restart
);
  localparam int CW = $clog2(TIMEOUT_CYC + 1);
  logic [CW-1:0] cnt_r;
  logic svc_d_r;
  logic state_r;
  logic backup_r;
  logic ret_pend_r;
  logic restart_r;
  wire strap_dis = (supervisor_wd_strap == STRAP_DIS_LEVEL);
  wire sup_en = en_line && !strap_dis;
  wire svc = svc_line && !svc_d_r;
  wire expire = sup_en && !svc && (cnt_r == CW'(TIMEOUT_CYC - 1));
  wire restart_any = expire || ext_restart;
  wire ret_now = reset_pushbutton || (isolated_reset && isolated_reset_strap);
  wire ret_arm = main_boot_return_strap || !clr_line;
  assign state = state_r;
  assign boot_backup = backup_r;
  assign module_restart = restart_r;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt_r <= '0;
      svc_d_r <= 1'b0;
      restart_r <= 1'b0;
    end else begin
      svc_d_r <= svc_line;
      restart_r <= expire;
      cnt_r <= (!sup_en || svc || expire) ? '0 : cnt_r + CW'(1);
    end
  end
  // latched state, set wins over clear
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_r <= 1'b0;
    end else begin
      state_r <= expire || (state_r && clr_line);
    end
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      backup_r <= 1'b0;
      ret_pend_r <= 1'b0;
    end else begin
      if (ret_now) begin
        backup_r <= 1'b0;
        ret_pend_r <= 1'b0;
      end else if (restart_any && (ret_pend_r || ret_arm)) begin
        backup_r <= 1'b0;
        ret_pend_r <= 1'b0;
      end else begin
        if (expire && backup_enable_strap) begin
          backup_r <= 1'b1;
        end
        if (!backup_enable_strap) begin
          backup_r <= 1'b0;
        end
        ret_pend_r <= ret_pend_r || ret_arm;
      end
    end
  end
  state_set_a: assert property (@(posedge clk) disable iff (!rstn) expire |=> state && module_restart)
    else $error("expiry not latched");
  state_clr_a: assert property (@(posedge clk) disable iff (!rstn) !clr_line && !expire |=> !state)
    else $error("line 3 low did not clear state");
  strap_off_a: assert property (@(posedge clk) disable iff (!rstn) strap_dis |=> cnt_r == '0)
    else $error("strap did not stop supervisor");
  main_only_a: assert property (@(posedge clk) disable iff (!rstn) !backup_enable_strap |=> !boot_backup)
    else $error("backup chosen without strap");
  to_backup_a: assert property (@(posedge clk) disable iff (!rstn)
    expire && backup_enable_strap && !ret_now && !ret_arm && !ret_pend_r |=> boot_backup)
    else $error("expiry did not select backup");
endmodule

// ==== core/twbs_top.sv ====
`timescale 1ns/1ps
module twbs_top import twbs_pkg::*; #(
  parameter int TICK_CYC = WD_TICK_CYC,
  parameter int SUP_TIMEOUT = SUP_TIMEOUT_CYC,
  parameter logic STRAP_DIS_LEVEL = 1'b1
) (
  input wire logic clk,
  input wire logic rstn,
  input wire twbs_io_req_t io_req,
  output logic [7:0] io_rdata,
  output twbs_evt_t wd_evt,
  input wire logic general_io_port_b_line1,
  input wire logic general_io_port_b_line2,
  input wire logic general_io_port_b_line3,
  output logic general_io_port_b_line4,
  input wire logic supervisor_wd_strap,
  input wire logic backup_enable_strap,
  input wire logic main_boot_return_strap,
  input wire logic isolated_reset_strap,
  input wire logic isolated_reset,
  input wire logic reset_pushbutton,
  output logic boot_backup,
  output logic module_restart,
  output logic indicator_header
);
  logic [7:0] idx_r;
  logic [7:0] rdata_r;
  logic sec_en_r;
  logic [3:0] sec_evt_r;
  logic [23:0] sec_int_r;
  logic sec_flag_r;
  logic fst_en_r;
  logic [3:0] fst_evt_r;
  logic [23:0] fst_int_r;
  logic fst_flag_r;
  twbs_evt_t evt_r;
  twbs_evt_t evt_nxt;
  logic sec_expire;
  logic fst_expire;
  logic sup_state;
  logic sup_backup;
  logic sup_restart;
  default clocking twbs_cb @(posedge clk); endclocking
  default disable iff (!rstn);

  // write strobes, direct ports
  wire wr = io_req.wr;
  wire [7:0] wd = io_req.wdata;
  wire wr_idx = wr && (io_req.addr == ADDR_IDX);
  wire wr_data = wr && (io_req.addr == ADDR_DATA);
  wire wr_sec_ctrl = wr && (io_req.addr == ADDR_SEC_CTRL);
  wire wr_sec_evt = wr && (io_req.addr == ADDR_SEC_EVT);
  wire wr_sec_lo = wr && (io_req.addr == ADDR_SEC_INT_LO);
  wire wr_sec_mid = wr && (io_req.addr == ADDR_SEC_INT_MID);
  wire wr_sec_hi = wr && (io_req.addr == ADDR_SEC_INT_HI);
  wire wr_sec_state = wr && (io_req.addr == ADDR_SEC_STATE);

  // indirect writes through the data port
  wire wr_fst_ctrl = wr_data && (idx_r == IDX_FST_CTRL);
  wire wr_fst_evt = wr_data && (idx_r == IDX_FST_EVT);
  wire wr_fst_lo = wr_data && (idx_r == IDX_FST_INT_LO);
  wire wr_fst_mid = wr_data && (idx_r == IDX_FST_INT_MID);
  wire wr_fst_hi = wr_data && (idx_r == IDX_FST_INT_HI);
  wire wr_fst_state = wr_data && (idx_r == IDX_FST_STATE);

  wire sec_restart = wr && (io_req.addr == ADDR_SEC_RESTART);
  wire fst_restart = (wr_fst_state && wd[RESTART_BIT]) || (wr && (io_req.addr == ADDR_FST_RESTART));

  wire sec_clr = wr_sec_state && wd[FLAG_BIT];
  wire fst_clr = wr_fst_state && wd[FLAG_BIT];

  wire twbs_wd_cfg_t sec_cfg = '{en: sec_en_r, interval: sec_int_r};
  wire twbs_wd_cfg_t fst_cfg = '{en: fst_en_r, interval: fst_int_r};

  // reserved bits forced to zero on read
  wire [7:0] sec_ctrl_rd = {1'b0, sec_en_r, 6'h00};
  wire [7:0] sec_evt_rd = {sec_evt_r, 4'h0};
  wire [7:0] sec_state_rd = {sec_flag_r, 7'h00};
  wire [7:0] fst_ctrl_rd = {1'b0, fst_en_r, 6'h00};
  wire [7:0] fst_evt_rd = {fst_evt_r, 4'h0};
  // bit 6 is write-only, so it never reads back
  wire [7:0] fst_state_rd = {fst_flag_r, 7'h00};

  wire [7:0] ind_rd =
    (idx_r == IDX_FST_CTRL) ? fst_ctrl_rd :
    (idx_r == IDX_FST_EVT) ? fst_evt_rd :
    (idx_r == IDX_FST_INT_LO) ? fst_int_r[7:0] :
    (idx_r == IDX_FST_INT_MID) ? fst_int_r[15:8] :
    (idx_r == IDX_FST_INT_HI) ? fst_int_r[23:16] :
    (idx_r == IDX_FST_STATE) ? fst_state_rd : 8'h00;

  // restart port reads zero, as does anything unmapped
  wire [7:0] rd_val =
    (io_req.addr == ADDR_IDX) ? idx_r :
    (io_req.addr == ADDR_DATA) ? ind_rd :
    (io_req.addr == ADDR_SEC_CTRL) ? sec_ctrl_rd :
    (io_req.addr == ADDR_SEC_EVT) ? sec_evt_rd :
    (io_req.addr == ADDR_SEC_INT_LO) ? sec_int_r[7:0] :
    (io_req.addr == ADDR_SEC_INT_MID) ? sec_int_r[15:8] :
    (io_req.addr == ADDR_SEC_INT_HI) ? sec_int_r[23:16] :
    (io_req.addr == ADDR_SEC_STATE) ? sec_state_rd : 8'h00;

  function automatic twbs_evt_t evt_decode(input logic [3:0] sel);
    twbs_evt_t e;
    e = '0;
    case (sel)
      4'h1: e.irq[3] = 1'b1;
      4'h2: e.irq[4] = 1'b1;
      4'h3: e.irq[5] = 1'b1;
      4'h4: e.irq[6] = 1'b1;
      4'h5: e.irq[7] = 1'b1;
      4'h6: e.irq[9] = 1'b1;
      4'h7: e.irq[10] = 1'b1;
      4'h8: e.irq[11] = 1'b1;
      4'h9: e.irq[12] = 1'b1;
      4'hA: e.irq[14] = 1'b1;
      4'hB: e.irq[15] = 1'b1;
      EVT_NMI: e.nmi = 1'b1;
      EVT_SYSRST: e.sysrst = 1'b1;
      // reserved codes raise nothing
      default: e = '0;
    endcase
    return e;
  endfunction

  // both timers may fire in one cycle, so events merge
  wire twbs_evt_t sec_evt_dec = sec_expire ? evt_decode(sec_evt_r) : twbs_evt_t'('0);
  wire twbs_evt_t fst_evt_dec = fst_expire ? evt_decode(fst_evt_r) : twbs_evt_t'('0);
  assign evt_nxt = sec_evt_dec | fst_evt_dec;

  assign io_rdata = rdata_r;
  assign wd_evt = evt_r;
  assign general_io_port_b_line4 = sup_state;
  assign boot_backup = sup_backup;
  assign module_restart = sup_restart;
  assign indicator_header = sup_state || sup_backup;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      idx_r <= 8'h00;
      rdata_r <= 8'h00;
      evt_r <= '0;
    end else begin
      if (wr_idx) begin
        idx_r <= wd;
      end
      if (io_req.rd) begin
        rdata_r <= rd_val;
      end
      evt_r <= evt_nxt;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sec_en_r <= SEC_CTRL_RST[EN_BIT];
      sec_evt_r <= SEC_EVT_RST[7:EVT_LSB];
      sec_int_r <= SEC_INT_RST;
    end else begin
      if (wr_sec_ctrl) begin
        sec_en_r <= wd[EN_BIT];
      end
      if (wr_sec_evt) begin
        sec_evt_r <= wd[7:EVT_LSB];
      end
      if (wr_sec_lo) begin
        sec_int_r[7:0] <= wd;
      end
      if (wr_sec_mid) begin
        sec_int_r[15:8] <= wd;
      end
      if (wr_sec_hi) begin
        sec_int_r[23:16] <= wd;
      end
    end
  end

  // first timer registers behind the index
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      fst_en_r <= FST_CTRL_RST[EN_BIT];
      fst_evt_r <= FST_EVT_RST[7:EVT_LSB];
      fst_int_r <= FST_INT_RST;
    end else begin
      if (wr_fst_ctrl) begin
        fst_en_r <= wd[EN_BIT];
      end
      if (wr_fst_evt) begin
        fst_evt_r <= wd[7:EVT_LSB];
      end
      if (wr_fst_lo) begin
        fst_int_r[7:0] <= wd;
      end
      if (wr_fst_mid) begin
        fst_int_r[15:8] <= wd;
      end
      if (wr_fst_hi) begin
        fst_int_r[23:16] <= wd;
      end
    end
  end

  // sticky flags, expiry beats a same-cycle clear
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sec_flag_r <= 1'b0;
      fst_flag_r <= 1'b0;
    end else begin
      sec_flag_r <= sec_expire || (sec_flag_r && !sec_clr);
      fst_flag_r <= fst_expire || (fst_flag_r && !fst_clr);
    end
  end

  twbs_timer #(.TICK_CYC(TICK_CYC)) u_sec (
    .clk(clk),
    .rstn(rstn),
    .cfg(sec_cfg),
    .restart(sec_restart),
    .expire(sec_expire)
  );

  twbs_timer #(.TICK_CYC(TICK_CYC)) u_fst (
    .clk(clk),
    .rstn(rstn),
    .cfg(fst_cfg),
    .restart(fst_restart),
    .expire(fst_expire)
  );

  // supervisor; system reset events also count as a restart for the return to main boot
  twbs_supervisor #(.TIMEOUT_CYC(SUP_TIMEOUT), .STRAP_DIS_LEVEL(STRAP_DIS_LEVEL)) u_sup (
    .clk(clk),
    .rstn(rstn),
    .svc_line(general_io_port_b_line1),
    .en_line(general_io_port_b_line2),
    .clr_line(general_io_port_b_line3),
    .supervisor_wd_strap(supervisor_wd_strap),
    .backup_enable_strap(backup_enable_strap),
    .main_boot_return_strap(main_boot_return_strap),
    .isolated_reset_strap(isolated_reset_strap),
    .isolated_reset(isolated_reset),
    .reset_pushbutton(reset_pushbutton),
    .ext_restart(evt_r.sysrst),
    .state(sup_state),
    .boot_backup(sup_backup),
    .module_restart(sup_restart)
  );

  sequence sec_fire_s;
    sec_expire && !sec_clr;
  endsequence
  sequence sec_clear_s;
    sec_clr && !sec_expire;
  endsequence

  sec_flag_set_a: assert property (@(posedge clk) disable iff (!rstn) sec_fire_s |=> sec_flag_r)
    else $error("second flag not set on expiry");
  sec_flag_clr_a: assert property (@(posedge clk) disable iff (!rstn) sec_clear_s |=> !sec_flag_r)
    else $error("second flag not cleared");
  fst_flag_a: assert property (@(posedge clk) disable iff (!rstn) fst_expire |=> fst_flag_r)
    else $error("first flag lost expiry");
  sec_en_wr_a: assert property (@(posedge clk) disable iff (!rstn) wr_sec_ctrl |=> sec_en_r == $past(wd[EN_BIT]))
    else $error("enable bit not stored");
  evt_nmi_a: assert property (@(posedge clk) disable iff (!rstn)
    sec_expire && sec_evt_r == EVT_NMI |=> wd_evt.nmi)
    else $error("nmi not raised");
  evt_sysrst_a: assert property (@(posedge clk) disable iff (!rstn)
    (fst_expire && fst_evt_r == EVT_SYSRST) || (sec_expire && sec_evt_r == EVT_SYSRST)
    |=> wd_evt.sysrst ##1 !wd_evt.sysrst)
    else $error("system reset not a single pulse");
  int_mid_wr_a: assert property (@(posedge clk) disable iff (!rstn) wr_sec_mid |=> sec_int_r[15:8] == $past(wd))
    else $error("middle interval byte not stored");
  rsvd_read_a: assert property (@(posedge clk) disable iff (!rstn)
    io_req.rd && io_req.addr == ADDR_SEC_STATE |=> io_rdata[6:0] == 7'h00)
    else $error("reserved state bits not zero");
  restart_rd_a: assert property (@(posedge clk) disable iff (!rstn)
    io_req.rd && io_req.addr == ADDR_SEC_RESTART |=> io_rdata == 8'h00)
    else $error("restart port read not zero");
  lamp_a: assert property (@(posedge clk) disable iff (!rstn) sup_backup |-> indicator_header)
    else $error("indicator dark while on backup");
  sequence idx_wr_s;
    wr_idx;
  endsequence
  idx_wr_a: assert property (idx_wr_s |=> idx_r == $past(wd))
    else $error("index not stored");
  sequence fst_ctrl_wr_s;
    wr_fst_ctrl;
  endsequence
  fst_en_wr_a: assert property (fst_ctrl_wr_s |=> fst_en_r == $past(wd[EN_BIT]))
    else $error("first enable not stored");
  sequence sec_evt_wr_s;
    wr_sec_evt;
  endsequence
  evt_sel_wr_a: assert property (sec_evt_wr_s |=> sec_evt_r == $past(wd[7:EVT_LSB]))
    else $error("event select not stored");
  sequence sec_lo_wr_s;
    wr_sec_lo;
  endsequence
  int_lo_wr_a: assert property (sec_lo_wr_s |=> sec_int_r[7:0] == $past(wd))
    else $error("low interval byte not stored");
  sequence sec_hi_wr_s;
    wr_sec_hi;
  endsequence
  int_hi_wr_a: assert property (sec_hi_wr_s |=> sec_int_r[23:16] == $past(wd))
    else $error("high interval byte not stored");
  sequence sec_restart_s;
    sec_restart;
  endsequence
  sec_restart_a: assert property (sec_restart_s |=> !sec_expire)
    else $error("second timer expired across restart");
  sequence fst_restart_s;
    fst_restart;
  endsequence
  fst_restart_a: assert property (fst_restart_s |=> !fst_expire)
    else $error("first timer expired across restart");
  sequence sec_off_s;
    !sec_en_r;
  endsequence
  sec_off_a: assert property (sec_off_s |=> !sec_expire)
    else $error("disabled timer expired");
  sequence fst_clear_s;
    fst_clr && !fst_expire;
  endsequence
  fst_flag_clr_a: assert property (fst_clear_s |=> !fst_flag_r)
    else $error("first flag not cleared");
  sequence ctrl_rd_s;
    io_req.rd && io_req.addr == ADDR_SEC_CTRL;
  endsequence
  ctrl_rsvd_a: assert property (ctrl_rd_s |=> io_rdata[7] == 1'b0 && io_rdata[5:0] == 6'h00)
    else $error("reserved control bits not zero");
  sequence rsvd_code_s;
    sec_expire && !fst_expire && (sec_evt_r == 4'h0 || sec_evt_r > EVT_SYSRST);
  endsequence
  rsvd_code_a: assert property (rsvd_code_s |=> wd_evt == '0)
    else $error("reserved code raised an event");
  sequence irq3_code_s;
    sec_expire && !fst_expire && sec_evt_r == 4'h1;
  endsequence
  irq3_code_a: assert property (irq3_code_s |=> wd_evt.irq == 16'h0008)
    else $error("code 1 did not raise irq 3");
endmodule

// ==== verification/twbs_top_bench.sv ====
`timescale 1ns/1ps
module twbs_top_bench import twbs_pkg::*;;
  // short counts keep the run brief; expectations follow these values
  localparam int TCK = 4;
  localparam int SUPT = 50;
  logic clk;
  logic rstn;
  twbs_io_req_t io_req;
  logic [7:0] io_rdata;
  twbs_evt_t wd_evt;
  logic line1, line2, line3, line4;
  logic sup_strap, bak_strap, ret_strap, iso_strap, iso_rst, pushb;
  logic boot_backup, module_restart, indicator;
  int num_errors;
  int tests_run;
  int cyc;
  int npulse;
  twbs_evt_t acc;

  twbs_top #(.TICK_CYC(TCK), .SUP_TIMEOUT(SUPT), .STRAP_DIS_LEVEL(1'b1)) uut (
    .clk(clk), .rstn(rstn), .io_req(io_req), .io_rdata(io_rdata), .wd_evt(wd_evt),
    .general_io_port_b_line1(line1), .general_io_port_b_line2(line2),
    .general_io_port_b_line3(line3), .general_io_port_b_line4(line4),
    .supervisor_wd_strap(sup_strap), .backup_enable_strap(bak_strap),
    .main_boot_return_strap(ret_strap), .isolated_reset_strap(iso_strap),
    .isolated_reset(iso_rst), .reset_pushbutton(pushb), .boot_backup(boot_backup),
    .module_restart(module_restart), .indicator_header(indicator)
  );

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic report_and_stop();
    if (num_errors == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic ok(input logic c, input string what);
    tests_run++;
    if (c !== 1'b1) begin
      num_errors++;
      $display("ERROR at %0t: %s", $time, what);
    end
  endtask

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    io_req <= '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
    @(posedge clk);
    io_req.wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
    @(posedge clk);
    io_req <= '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
    @(posedge clk);
    io_req.rd <= 1'b0;
    #1;
    chk8(io_rdata, exp, what);
  endtask

  // gathers expiry events; cyc is the cycle of the first one
  task automatic watch(input int n);
    acc = '0;
    npulse = 0;
    cyc = -1;
    for (int k = 1; k <= n; k++) begin
      @(posedge clk);
      #1;
      if (wd_evt !== '0) begin
        if (cyc < 0) cyc = k;
        npulse++;
        acc = acc | wd_evt;
      end
    end
  endtask

  function automatic twbs_evt_t evt_of(input int c);
    int lines[11] = '{3, 4, 5, 6, 7, 9, 10, 11, 12, 14, 15};
    evt_of = '0;
    if (c >= 1 && c <= 11) evt_of.irq[lines[c-1]] = 1'b1;
    evt_of.nmi = (c == int'(EVT_NMI));
    evt_of.sysrst = (c == int'(EVT_SYSRST));
  endfunction

  // runs the supervisor with line 2 at en, stops at the first restart pulse
  task automatic sup_run(input logic en, input int n, input logic fire, input logic exp_bk);
    int k;
    k = 0;
    @(posedge clk);
    line2 <= en;
    do begin
      @(posedge clk);
      #1;
      k++;
    end while (module_restart !== 1'b1 && k < n);
    @(posedge clk);
    line2 <= 1'b0;
    #1;
    ok(module_restart === 1'b0, "restart pulse too long");
    if (fire) begin
      ok(k >= SUPT - 1 && k <= SUPT + 2, "supervisor timeout");
      ok(line4 === 1'b1, "line 4 not set");
      ok(indicator === 1'b1, "indicator off");
    end else ok(k == n, "unexpected restart");
    ok(boot_backup === exp_bk, "boot select");
    // hand back on an edge so the caller drives pins there
    @(posedge clk);
  endtask

  initial begin
    #(25 * 20000);
    num_errors++;
    report_and_stop();
  end

  initial begin
    io_req = '0;
    rstn = 1'b0;
    line1 = 1'b0;
    line2 = 1'b0;
    line3 = 1'b1;
    sup_strap = 1'b0;
    bak_strap = 1'b0;
    ret_strap = 1'b0;
    iso_strap = 1'b0;
    iso_rst = 1'b0;
    pushb = 1'b0;
    num_errors = 0;
    tests_run = 0;
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    for (int a = 8'h68; a <= 8'h6D; a++) rd(8'(a), 8'h00, "reset value");
    wr(ADDR_SEC_CTRL, 8'hFF);
    rd(ADDR_SEC_CTRL, 8'h40, "ctrl bits");
    wr(ADDR_SEC_CTRL, 8'h00);
    // the brief enable at interval zero can expire; drop its flag
    wr(ADDR_SEC_STATE, 8'h80);
    wr(ADDR_SEC_EVT, 8'hFF);
    rd(ADDR_SEC_EVT, 8'hF0, "event bits");
    wr(ADDR_SEC_STATE, 8'h7F);
    rd(ADDR_SEC_STATE, 8'h00, "state bits");
    rd(ADDR_SEC_RESTART, 8'h00, "restart port read");
    wr(8'h70, 8'h55);
    rd(8'h70, 8'h00, "unmapped port");
    for (int i = 0; i < 3; i++) wr(ADDR_SEC_INT_LO + 8'(i), 8'h11 * 8'(i + 1));
    for (int i = 0; i < 3; i++) rd(ADDR_SEC_INT_LO + 8'(i), 8'h11 * 8'(i + 1), "interval byte");
    wr(ADDR_SEC_INT_LO, 8'h03);
    wr(ADDR_SEC_INT_MID, 8'h00);
    wr(ADDR_SEC_INT_HI, 8'h00);
    wr(ADDR_SEC_EVT, 8'hB0);
    wr(ADDR_SEC_CTRL, 8'h40);
    watch(30);
    ok(cyc >= 3 * TCK && cyc <= 3 * TCK + 3, "tick period");
    ok(npulse == 1 && acc === evt_of(11), "expiry event");
    rd(ADDR_SEC_STATE, 8'h80, "flag set");
    wr(ADDR_SEC_STATE, 8'h80);
    rd(ADDR_SEC_STATE, 8'h00, "flag cleared");
    wr(ADDR_SEC_RESTART, 8'hA5);
    watch(8);
    wr(ADDR_SEC_RESTART, 8'h00);
    watch(30);
    ok(cyc >= 3 * TCK && cyc <= 3 * TCK + 3, "restart timing");
    wr(ADDR_SEC_CTRL, 8'h00);
    wr(ADDR_SEC_INT_LO, 8'h01);
    for (int c = 0; c < 16; c++) begin
      wr(ADDR_SEC_EVT, 8'(c << 4));
      wr(ADDR_SEC_STATE, 8'h80);
      wr(ADDR_SEC_CTRL, 8'h40);
      watch(20);
      wr(ADDR_SEC_CTRL, 8'h00);
      ok(acc === evt_of(c), "event code");
      ok(npulse == ((c == 0 || c > 13) ? 0 : 1), "event count");
      rd(ADDR_SEC_STATE, 8'h80, "flag on any code");
    end
    wr(ADDR_IDX, IDX_FST_STATE);
    rd(ADDR_IDX, IDX_FST_STATE, "index port");
    rd(ADDR_DATA, 8'h00, "first state reset");
    wr(ADDR_IDX, IDX_FST_CTRL);
    wr(ADDR_DATA, 8'h00);
    wr(ADDR_IDX, IDX_FST_EVT);
    wr(ADDR_DATA, 8'hC0);
    wr(ADDR_IDX, IDX_FST_INT_LO);
    wr(ADDR_DATA, 8'h01);
    wr(ADDR_IDX, IDX_FST_INT_HI);
    wr(ADDR_DATA, 8'h00);
    wr(ADDR_IDX, IDX_FST_CTRL);
    wr(ADDR_DATA, 8'h40);
    watch(20);
    ok(npulse == 1 && acc === evt_of(12), "first timer event");
    wr(ADDR_IDX, IDX_FST_STATE);
    rd(ADDR_DATA, 8'h80, "first flag");
    wr(ADDR_DATA, 8'h80);
    rd(ADDR_DATA, 8'h00, "first flag clear");
    wr(ADDR_DATA, 8'h40);
    watch(20);
    ok(npulse == 1, "first restart");
    rd(ADDR_DATA, 8'h80, "restart bit reads 0");
    wr(ADDR_FST_RESTART, 8'h00);
    watch(20);
    ok(npulse == 1 && acc === evt_of(12), "first restart port");
    wr(ADDR_IDX, IDX_FST_CTRL);
    wr(ADDR_DATA, 8'h00);
    // rising edge on line 1 every 20 cycles services the supervisor
    @(posedge clk);
    line2 <= 1'b1;
    npulse = 0;
    for (int k = 0; k < 160; k++) begin
      @(posedge clk);
      if (k % 10 == 0) line1 <= ~line1;
      if (module_restart !== 1'b0) npulse++;
    end
    line2 <= 1'b0;
    ok(npulse == 0 && line4 === 1'b0, "serviced supervisor");
    sup_strap <= 1'b1;
    sup_run(1'b1, 120, 1'b0, 1'b0);
    sup_strap <= 1'b0;
    sup_run(1'b0, 120, 1'b0, 1'b0);
    sup_run(1'b1, 80, 1'b1, 1'b0);
    line3 <= 1'b0;
    @(posedge clk);
    line3 <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    ok(line4 === 1'b0 && indicator === 1'b0, "line 3 clear");
    @(posedge clk);
    bak_strap <= 1'b1;
    sup_run(1'b1, 80, 1'b1, 1'b0);
    sup_run(1'b1, 80, 1'b1, 1'b1);
    sup_run(1'b1, 80, 1'b1, 1'b1);
    pushb <= 1'b1;
    @(posedge clk);
    pushb <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    ok(boot_backup === 1'b0, "pushbutton return");
    sup_run(1'b1, 80, 1'b1, 1'b1);
    iso_rst <= 1'b1;
    @(posedge clk);
    iso_rst <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    ok(boot_backup === 1'b1, "isolated reset not strapped");
    @(posedge clk);
    iso_strap <= 1'b1;
    iso_rst <= 1'b1;
    @(posedge clk);
    iso_rst <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    ok(boot_backup === 1'b0, "isolated reset return");
    sup_run(1'b1, 80, 1'b1, 1'b1);
    ret_strap <= 1'b1;
    @(posedge clk);
    ret_strap <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    ok(boot_backup === 1'b1, "return waits for restart");
    sup_run(1'b1, 80, 1'b1, 1'b0);
    sup_run(1'b1, 80, 1'b1, 1'b1);
    @(posedge clk);
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    #1;
    ok(boot_backup === 1'b0 && line4 === 1'b0, "power-up main");
    report_and_stop();
  end
endmodule
